// ---- hdl/agc_gain_control.sv ----
// Purpose: digital gain control loop with carrier sense and avalon register access
// Assumes: inputs synchronous to mclk; sample_strobe is the channel-filter rate enable
// Notes: registers are 8 bits wide in the low byte of each 32-bit word
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "agc_defines.svh"

module agc_gain_control (
    input wire logic mclk, // 25 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic sample_strobe, // channel-filter sample enable
    input wire logic [6:0] amplitude_db, // channel-filter amplitude
    input wire logic [6:0] rssi_db, // signal strength
    input wire logic sync_found, // sync word pulse
    input wire logic search_restart, // new packet search pulse
    output logic [2:0] analog_gain, // analogue gain step
    output logic [2:0] digital_gain, // digital gain step
    output logic carrier_sense, // carrier present
    output logic [4:0] ook_boundary_db // ook decision boundary
);

    agc_pkg::agc_main_state_type st_reg; // registered state
    agc_pkg::agc_main_state_type st_next; // next state
    logic avg_valid; // average ready
    logic [6:0] avg_value; // averaged amplitude
    logic [5:0] goal_db; // decoded goal
    logic signed [7:0] dev; // average minus goal
    logic signed [8:0] thr; // absolute threshold
    logic too_high; // above zone
    logic too_low; // below zone
    logic analog_free; // analogue may move
    logic digital_free; // digital may move
    logic [5:0] idx; // register index
    logic hit; // access in progress

    // settle length per code
    function automatic logic [5:0] wait_samples(input logic [1:0] code);
        case (code)
            2'h0: wait_samples = `AGC_WAIT_0;
            2'h1: wait_samples = `AGC_WAIT_1;
            2'h2: wait_samples = `AGC_WAIT_2;
            default: wait_samples = `AGC_WAIT_3;
        endcase
    endfunction

    // goal in dB per code
    function automatic logic [5:0] goal_of(input logic [2:0] code);
        case (code)
            3'h0: goal_of = `AGC_GOAL_0;
            3'h1: goal_of = `AGC_GOAL_1;
            3'h2: goal_of = `AGC_GOAL_2;
            3'h3: goal_of = `AGC_GOAL_3;
            3'h4: goal_of = `AGC_GOAL_4;
            3'h5: goal_of = `AGC_GOAL_5;
            3'h6: goal_of = `AGC_GOAL_6;
            default: goal_of = `AGC_GOAL_7;
        endcase
    endfunction

    // dead zone below the goal
    function automatic logic [3:0] zone_lo(input logic [1:0] code);
        case (code)
            2'h0: zone_lo = `AGC_DZ_LO_0;
            2'h1: zone_lo = `AGC_DZ_LO_1;
            2'h2: zone_lo = `AGC_DZ_LO_2;
            default: zone_lo = `AGC_DZ_LO_3;
        endcase
    endfunction

    // dead zone above the goal
    function automatic logic [3:0] zone_hi(input logic [1:0] code);
        case (code)
            2'h0: zone_hi = `AGC_DZ_HI_0;
            2'h1: zone_hi = `AGC_DZ_HI_1;
            2'h2: zone_hi = `AGC_DZ_HI_2;
            default: zone_hi = `AGC_DZ_HI_3;
        endcase
    endfunction

    // ook boundary per averaging code
    function automatic logic [4:0] ook_of(input logic [1:0] code);
        case (code)
            2'h0: ook_of = `AGC_OOK_0;
            2'h1: ook_of = `AGC_OOK_1;
            2'h2: ook_of = `AGC_OOK_2;
            default: ook_of = `AGC_OOK_3;
        endcase
    endfunction

    // amplitude averager
    agc_avg u_avg (
        .mclk(mclk),
        .reset_n(reset_n),
        .sample_strobe(sample_strobe),
        .amplitude(amplitude_db),
        .clear(st_reg.acc_clear),
        .length_code(st_reg.cfg[`AGC_F_FILT]),
        .avg_valid(avg_valid),
        .avg_value(avg_value)
    );

    // loop arithmetic
    always_comb begin
        goal_db = goal_of(st_reg.lim[`AGC_F_GOAL]);
        dev = $signed({1'b0, avg_value}) - $signed({2'b00, goal_db});
        // zone edges differ above and below for the asymmetric codes
        too_high = dev > $signed({4'h0, zone_hi(st_reg.cfg[`AGC_F_HYST])});
        too_low = dev < -$signed({4'h0, zone_lo(st_reg.cfg[`AGC_F_HYST])});
        // threshold is goal plus signed dB code
        thr = $signed({3'b000, goal_db}) + $signed({{5{st_reg.lim[3]}}, st_reg.lim[`AGC_F_THR]});
        // analogue frozen in modes 10 and 11
        analog_free = st_reg.cfg[`AGC_F_HOLD] == `AGC_HOLD_NONE
            || (st_reg.cfg[`AGC_F_HOLD] == `AGC_HOLD_SYNC && !st_reg.sync_hold);
        digital_free = analog_free || st_reg.cfg[`AGC_F_HOLD] == `AGC_HOLD_ANALOG;
    end

    // register access, gain loop and carrier sense
    always_comb begin
        st_next = st_reg;
        idx = avs_address[7:2];
        hit = (avs_read || avs_write) && st_reg.waitreq;

        // avalon: answer one cycle after the request, write lands then
        if (hit) begin
            st_next.waitreq = 1'b0;
            case (idx)
                `AGC_IDX_LIMITS: st_next.rdata = st_reg.lim;
                `AGC_IDX_CONFIG: st_next.rdata = st_reg.cfg;
                `AGC_IDX_MANUAL: st_next.rdata = st_reg.man;
                `AGC_IDX_STATUS: st_next.rdata = {st_reg.sync_hold, st_reg.cs,
                    st_reg.dgain, st_reg.again};
                default: st_next.rdata = 8'h00; // unmapped reads zero
            endcase
        end else begin
            st_next.waitreq = 1'b1;
        end
        if (avs_write && !st_reg.waitreq && avs_byteenable[0]) begin
            case (idx)
                `AGC_IDX_LIMITS: st_next.lim = {1'b0, avs_writedata[6:0]};
                `AGC_IDX_CONFIG: st_next.cfg = avs_writedata[7:0];
                `AGC_IDX_MANUAL: st_next.man = {2'b00, avs_writedata[5:0]};
                default: st_next.lim = st_reg.lim; // unmapped or read-only
            endcase
        end

        // sync hold: a sync in the same cycle as a restart wins
        if (sync_found) begin
            st_next.sync_hold = 1'b1;
        end else if (search_restart) begin
            st_next.sync_hold = 1'b0;
        end

        // ook boundary follows averaging code
        st_next.ook_db = ook_of(st_reg.cfg[`AGC_F_FILT]);

        // carrier sense, disabled by the most negative code
        if (st_reg.lim[`AGC_F_THR] == `AGC_THR_OFF) begin
            st_next.cs = 1'b0;
        end else if (sample_strobe) begin
            st_next.cs = $signed({2'b00, rssi_db}) >= thr;
        end

        case (st_reg.phase)
            agc_pkg::PH_SETTLE: begin
                // skip samples before accumulating again
                st_next.acc_clear = 1'b1;
                if (sample_strobe) begin
                    if (st_reg.settle <= `AGC_SETTLE_LAST) begin
                        st_next.phase = agc_pkg::PH_MEASURE;
                        st_next.acc_clear = 1'b0;
                        st_next.settle = 6'h00;
                    end else begin
                        st_next.settle = st_reg.settle - 6'h01;
                    end
                end
            end
            agc_pkg::PH_MEASURE: begin
                st_next.acc_clear = 1'b0;
                // act only on a full average outside the zone
                if (avg_valid && (too_high || too_low)) begin
                    if (too_high && analog_free && st_reg.again != `AGC_GAIN_MIN) begin
                        st_next.again = st_reg.again - 3'h1;
                    end else if (too_high && digital_free
                        && st_reg.dgain != `AGC_GAIN_MIN) begin
                        st_next.dgain = st_reg.dgain - 3'h1;
                    end else if (too_low && analog_free
                        && st_reg.again != `AGC_GAIN_MAX) begin
                        st_next.again = st_reg.again + 3'h1;
                    end else if (too_low && digital_free
                        && st_reg.dgain != `AGC_GAIN_MAX) begin
                        st_next.dgain = st_reg.dgain + 3'h1;
                    end
                    // any real step restarts the settle wait
                    if (st_next.again != st_reg.again || st_next.dgain != st_reg.dgain) begin
                        st_next.phase = agc_pkg::PH_SETTLE;
                        st_next.settle = wait_samples(st_reg.cfg[`AGC_F_WAIT]);
                        st_next.acc_clear = 1'b1;
                    end
                end
            end
            default: begin
                st_next.phase = agc_pkg::PH_SETTLE;
            end
        endcase

        // full hold: software owns both gains
        if (st_reg.cfg[`AGC_F_HOLD] == `AGC_HOLD_ALL) begin
            st_next.again = st_reg.man[`AGC_F_AGAIN];
            st_next.dgain = st_reg.man[`AGC_F_DGAIN];
        end
    end

    // state register; loop starts by settling
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg.waitreq <= 1'b1;
            st_reg.rdata <= 8'h00;
            st_reg.cfg <= `AGC_CONFIG_RESET;
            st_reg.lim <= `AGC_LIMITS_RESET;
            st_reg.man <= `AGC_MANUAL_RESET;
            st_reg.again <= `AGC_GAIN_MAX;
            st_reg.dgain <= `AGC_GAIN_MAX;
            st_reg.sync_hold <= 1'b0;
            st_reg.settle <= `AGC_WAIT_1;
            st_reg.phase <= agc_pkg::PH_SETTLE;
            st_reg.acc_clear <= 1'b1;
            st_reg.cs <= 1'b0;
            st_reg.ook_db <= `AGC_OOK_1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign avs_readdata = {24'h000000, st_reg.rdata};
    assign avs_waitrequest = st_reg.waitreq;
    assign analog_gain = st_reg.again;
    assign digital_gain = st_reg.dgain;
    assign carrier_sense = st_reg.cs;
    assign ook_boundary_db = st_reg.ook_db;

endmodule // agc_gain_control

// ---- hdl/agc_defines.svh ----
// Purpose: register map, field positions, reset values and code tables for the gain control
// Assumes: included by bare name from the design modules
// Notes: definitions only
`ifndef AGC_DEFINES_SVH
`define AGC_DEFINES_SVH

// register indices, byte address is four times the index
`define AGC_IDX_LIMITS 6'h1C
`define AGC_IDX_CONFIG 6'h1D
`define AGC_IDX_MANUAL 6'h1E
`define AGC_IDX_STATUS 6'h1F

// reset values
`define AGC_CONFIG_RESET 8'h91
`define AGC_LIMITS_RESET 8'h30
`define AGC_MANUAL_RESET 8'h00

// gain_control_config fields
`define AGC_F_HYST 7:6
`define AGC_F_WAIT 5:4
`define AGC_F_HOLD 3:2
`define AGC_F_FILT 1:0
// gain_limits_config fields
`define AGC_F_GOAL 6:4
`define AGC_F_THR 3:0
// manual gain / status fields
`define AGC_F_AGAIN 2:0
`define AGC_F_DGAIN 5:3
`define AGC_B_CS 6
`define AGC_B_SYNC 7

// gain hold select codes
`define AGC_HOLD_NONE 2'h0
`define AGC_HOLD_SYNC 2'h1
`define AGC_HOLD_ANALOG 2'h2
`define AGC_HOLD_ALL 2'h3

// threshold code that turns absolute carrier sense off
`define AGC_THR_OFF 4'h8

// gain step limits
`define AGC_GAIN_MIN 3'h0
`define AGC_GAIN_MAX 3'h7

// settle wait in channel-filter samples
`define AGC_WAIT_0 6'h08
`define AGC_WAIT_1 6'h10
`define AGC_WAIT_2 6'h18
`define AGC_WAIT_3 6'h20
`define AGC_SETTLE_LAST 6'h01

// averaging window: sample count and divide shift
`define AGC_WIN_0 7'h08
`define AGC_WIN_1 7'h10
`define AGC_WIN_2 7'h20
`define AGC_WIN_3 7'h40
`define AGC_SHIFT_0 3'h3
`define AGC_SHIFT_1 3'h4
`define AGC_SHIFT_2 3'h5
`define AGC_SHIFT_3 3'h6

// on-off keying decision boundary in dB
`define AGC_OOK_0 5'h04
`define AGC_OOK_1 5'h08
`define AGC_OOK_2 5'h0C
`define AGC_OOK_3 5'h10

// amplitude goal in dB
`define AGC_GOAL_0 6'h18
`define AGC_GOAL_1 6'h1B
`define AGC_GOAL_2 6'h1E
`define AGC_GOAL_3 6'h21
`define AGC_GOAL_4 6'h24
`define AGC_GOAL_5 6'h26
`define AGC_GOAL_6 6'h28
`define AGC_GOAL_7 6'h2A

// dead zone below (lo) and above (hi) the goal, in dB
`define AGC_DZ_LO_0 4'h2
`define AGC_DZ_HI_0 4'h2
`define AGC_DZ_LO_1 4'h2
`define AGC_DZ_HI_1 4'h4
`define AGC_DZ_LO_2 4'h3
`define AGC_DZ_HI_2 4'h6
`define AGC_DZ_LO_3 4'h4
`define AGC_DZ_HI_3 4'h8

`endif

// ---- hdl/agc_pkg.sv ----
// Purpose: shared types of the gain control
// Assumes: needs no constants; agc_defines.svh is not included here
// Notes: types only
package agc_pkg;

    // control loop phase
    typedef enum logic {
        PH_SETTLE,
        PH_MEASURE
    } agc_phase_type;

    // averager state
    typedef struct packed {
        logic [12:0] sum; // running sum of amplitudes
        logic [6:0] cnt; // samples taken
        logic [6:0] avg; // last average
        logic valid; // one-cycle average strobe
    } agc_avg_state_type;

    // main block state
    typedef struct packed {
        logic waitreq; // avalon waitrequest
        logic [7:0] rdata; // read data
        logic [7:0] cfg; // gain_control_config
        logic [7:0] lim; // gain_limits_config
        logic [7:0] man; // manual gain
        logic [2:0] again; // analogue gain step
        logic [2:0] dgain; // digital gain step
        logic sync_hold; // sync seen, gain held
        logic [5:0] settle; // samples left to skip
        agc_phase_type phase; // loop phase
        logic acc_clear; // hold averager empty
        logic cs; // carrier sense
        logic [4:0] ook_db; // ook boundary
    } agc_main_state_type;

endpackage

// ---- hdl/agc_avg.sv ----
// Purpose: amplitude averager over a selectable channel-filter sample window
// Assumes: sample_strobe marks one valid amplitude per channel-filter sample
// Notes: window restarts whenever clear is high
`timescale 1ns/1ps
`include "agc_defines.svh"

module agc_avg (
    input wire logic mclk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic sample_strobe, // one channel-filter sample
    input wire logic [6:0] amplitude, // amplitude in dB
    input wire logic clear, // discard partial window
    input wire logic [1:0] length_code, // window length code
    output logic avg_valid, // average ready pulse
    output logic [6:0] avg_value // averaged amplitude
);

    agc_pkg::agc_avg_state_type st_reg; // registered state
    agc_pkg::agc_avg_state_type st_next; // next state
    logic [6:0] win; // window length
    logic [2:0] shift; // divide shift
    logic [12:0] sum_add; // sum with current sample
    logic [12:0] quot; // shifted sum

    // window decode
    always_comb begin
        case (length_code)
            2'h0: begin win = `AGC_WIN_0; shift = `AGC_SHIFT_0; end
            2'h1: begin win = `AGC_WIN_1; shift = `AGC_SHIFT_1; end
            2'h2: begin win = `AGC_WIN_2; shift = `AGC_SHIFT_2; end
            default: begin win = `AGC_WIN_3; shift = `AGC_SHIFT_3; end
        endcase
    end

    // accumulate and divide
    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        sum_add = st_reg.sum + {6'h00, amplitude};
        quot = sum_add >> shift;
        if (clear) begin
            // settle wait: nothing accumulates
            st_next.sum = 13'h0000;
            st_next.cnt = 7'h00;
        end else if (sample_strobe) begin
            if (st_reg.cnt + 7'h01 > win) begin
                // window shortened mid-way: stale partial sum dropped, restart here
                st_next.sum = {6'h00, amplitude};
                st_next.cnt = 7'h01;
            end else if (st_reg.cnt + 7'h01 == win) begin
                st_next.avg = quot[6:0];
                st_next.valid = 1'b1;
                st_next.sum = 13'h0000;
                st_next.cnt = 7'h00;
            end else begin
                st_next.sum = sum_add;
                st_next.cnt = st_reg.cnt + 7'h01;
            end
        end
    end

    // state register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avg_valid = st_reg.valid;
    assign avg_value = st_reg.avg;

endmodule // agc_avg

// ---- tb/agc_gain_checker.sv ----
// Purpose: port-level assertions for the gain control block
// Assumes: sees only ports of agc_gain_control; a single clock domain
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps

module agc_gain_checker (
    input wire logic mclk, // clock
    input wire logic reset_n, // async reset, active low
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic sample_strobe, // sample enable
    input wire logic [2:0] analog_gain, // analogue step
    input wire logic [2:0] digital_gain, // digital step
    input wire logic carrier_sense, // carrier flag
    input wire logic [4:0] ook_boundary_db // ook boundary
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    logic [3:0] wr_hist; // recent writes, newest in bit 0
    logic [3:0] stb_hist; // recent strobes, newest in bit 0

    // short history: an output may only move a few edges after its cause
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_hist <= 4'h0;
            stb_hist <= 4'h0;
        end else begin
            wr_hist <= {wr_hist[2:0], avs_write};
            stb_hist <= {stb_hist[2:0], sample_strobe};
        end
    end

    AST_WAIT_PULSE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest dropped without a request");
    AST_RDATA_HI: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    AST_RDATA_HOLD: assert property (!$fell(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved outside an answer");
    AST_OOK_SET: assert property (ook_boundary_db inside {5'h04, 5'h08, 5'h0C, 5'h10})
        else $error("ook boundary off its table");
    AST_OOK_CAUSE: assert property ($changed(ook_boundary_db) |-> wr_hist != 4'h0)
        else $error("ook boundary moved without a write");
    AST_CS_CAUSE: assert property ($changed(carrier_sense) |-> stb_hist[0] || wr_hist != 4'h0)
        else $error("carrier sense moved without a strobe");
    AST_GAIN_CAUSE: assert property ($changed({analog_gain, digital_gain}) |->
        stb_hist != 4'h0 || wr_hist != 4'h0)
        else $error("gain moved without a sample or write");

    // main scenarios reached
    COV_READ: cover property (avs_read && !avs_waitrequest);
    COV_GAIN: cover property ($changed(analog_gain));
    COV_CS: cover property ($rose(carrier_sense));
endmodule // agc_gain_checker

bind agc_gain_control agc_gain_checker u_chk (
    .mclk(mclk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_strobe(sample_strobe), .analog_gain(analog_gain), .digital_gain(digital_gain),
    .carrier_sense(carrier_sense), .ook_boundary_db(ook_boundary_db)
);

// ---- tb/agc_gain_control_test.sv ----
// Purpose: directed test of the gain control through its register bus and sample inputs
// Assumes: strobes four clocks apart, so a gain decision never meets a strobe
// Notes: gains read as {digital, analogue}, the low six status bits
`timescale 1ns/1ps

module agc_gain_control_test;
    logic mclk; // 25 MHz clock
    logic reset_n; // async reset, active low
    logic [7:0] avs_address; // byte address
    logic avs_read; // read request
    logic avs_write; // write request
    logic [31:0] avs_writedata; // write data
    logic [3:0] avs_byteenable; // byte lanes
    logic [31:0] avs_readdata; // read data
    logic avs_waitrequest; // stall
    logic sample_strobe; // sample enable
    logic [6:0] amplitude_db; // amplitude
    logic [6:0] rssi_db; // signal strength
    logic sync_found; // sync pulse
    logic search_restart; // restart pulse
    logic [2:0] analog_gain; // analogue step
    logic [2:0] digital_gain; // digital step
    logic carrier_sense; // carrier flag
    logic [4:0] ook_boundary_db; // ook boundary
    int mismatches; // failed compares
    int compares; // compares made
    int n; // strobes sent in last wait
    int thr; // expected threshold in dB
    logic [7:0] rd; // last read byte
    localparam int goal_db [8] = '{24, 27, 30, 33, 36, 38, 40, 42}; // goal per code

    agc_gain_control dut (
        .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_strobe(sample_strobe), .amplitude_db(amplitude_db), .rssi_db(rssi_db),
        .sync_found(sync_found), .search_restart(search_restart), .analog_gain(analog_gain),
        .digital_gain(digital_gain), .carrier_sense(carrier_sense),
        .ook_boundary_db(ook_boundary_db)
    );

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one bus cycle; held until waitrequest is sampled low, then an idle edge
    task automatic access(input logic wr_en, input logic [7:0] addr, input logic [7:0] wd,
                          input logic [3:0] be);
        int k;
        k = 0;
        avs_address <= addr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 20) begin
            mismatches++;
            summarize();
        end
        @(posedge mclk);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        access(1'b0, addr, 8'h00, 4'hF);
        check({24'h000000, rd}, {24'h000000, exp});
    endtask

    task automatic strobe_once();
        sample_strobe <= 1'b1;
        @(posedge mclk);
        sample_strobe <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // strobe until a gain moves; a missing move ends the run when one is required
    task automatic until_change(input int lim, input logic must);
        logic [5:0] g0;
        g0 = {digital_gain, analog_gain};
        n = 0;
        while ({digital_gain, analog_gain} === g0 && n < lim) begin
            strobe_once();
            n++;
        end
        if (must && n >= lim) begin
            mismatches++;
            summarize();
        end
    endtask

    initial begin
        reset_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        sample_strobe = 1'b0;
        amplitude_db = 7'h00;
        rssi_db = 7'h00;
        sync_found = 1'b0;
        search_restart = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        // reset values, unmapped place reads zero
        rd_chk(8'h70, 8'h30);
        rd_chk(8'h74, 8'h91);
        rd_chk(8'h78, 8'h00);
        rd_chk(8'h7C, 8'h3F);
        rd_chk(8'h80, 8'h00);
        check(32'(ook_boundary_db), 32'h8);
        // lane 0 off and read-only status: both writes dropped
        access(1'b1, 8'h70, 8'h55, 4'hE);
        access(1'b1, 8'h7C, 8'h00, 4'hF);
        rd_chk(8'h70, 8'h30);
        rd_chk(8'h7C, 8'h3F);
        // every averaging code; manual mode sets the gains from the manual register
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 8'h74, 8'h0C | 8'(i), 4'hF);
            repeat (2) @(posedge mclk);
            check(32'(ook_boundary_db), 32'(4 * i + 4));
        end
        access(1'b1, 8'h78, 8'h2A, 4'hF);
        repeat (2) @(posedge mclk);
        check(32'({digital_gain, analog_gain}), 32'h2A);
        rd_chk(8'h7C, 8'h2A);
        // every threshold code c, against goal code c mod 8: at threshold, one below
        for (int c = 0; c < 16; c++) begin
            access(1'b1, 8'h70, 8'(((c % 8) << 4) | c), 4'hF);
            thr = goal_db[c % 8] + ((c < 8) ? c : c - 16);
            rssi_db <= 7'(thr);
            strobe_once();
            check(32'(carrier_sense), 32'(c != 8));
            rssi_db <= 7'(thr - 1);
            strobe_once();
            check(32'(carrier_sense), 32'h0);
        end
        // loud input under manual hold: nothing moves
        rssi_db <= 7'h00;
        amplitude_db <= 7'h1B;
        access(1'b1, 8'h70, 8'h00, 4'hF);
        until_change(100, 1'b0);
        check(32'(n), 32'h64);
        // analogue held, digital steps down; 8 settle + 8 averaged
        access(1'b1, 8'h74, 8'h08, 4'hF);
        until_change(400, 1'b1);
        check(32'({digital_gain, analog_gain}), 32'h22);
        until_change(400, 1'b1);
        check(32'(n), 32'h10);
        check(32'({digital_gain, analog_gain}), 32'h1A);
        // large zone: 8 dB over goal stays put, 9 dB moves
        amplitude_db <= 7'h20;
        access(1'b1, 8'h74, 8'hF2, 4'hF);
        until_change(150, 1'b0);
        check(32'(n), 32'h96);
        amplitude_db <= 7'h21;
        until_change(400, 1'b1);
        check(32'({digital_gain, analog_gain}), 32'h19);
        until_change(400, 1'b1);
        check(32'(n), 32'h40);
        check(32'({digital_gain, analog_gain}), 32'h18);
        // freeze on sync, free again after a new search
        amplitude_db <= 7'h1B;
        access(1'b1, 8'h74, 8'h04, 4'hF);
        sync_found <= 1'b1;
        @(posedge mclk);
        sync_found <= 1'b0;
        rd_chk(8'h7C, 8'h98);
        until_change(100, 1'b0);
        check(32'(n), 32'h64);
        search_restart <= 1'b1;
        @(posedge mclk);
        search_restart <= 1'b0;
        until_change(400, 1'b1);
        check(32'({digital_gain, analog_gain}), 32'h10);
        // medium zone, 16-sample settle and window: 6 dB over stays, 7 dB moves
        amplitude_db <= 7'h1E;
        access(1'b1, 8'h74, 8'h91, 4'hF);
        until_change(100, 1'b0);
        check(32'(n), 32'h64);
        amplitude_db <= 7'h1F;
        until_change(400, 1'b1);
        check(32'({digital_gain, analog_gain}), 32'h08);
        until_change(400, 1'b1);
        check(32'(n), 32'h20);
        check(32'({digital_gain, analog_gain}), 32'h00);
        // quiet input: gain steps back up, analogue first
        amplitude_db <= 7'h10;
        until_change(400, 1'b1);
        check(32'({digital_gain, analog_gain}), 32'h01);
        summarize();
    end
endmodule // agc_gain_control_test
